// file: logic/pcmc_defines.vh
// Constants for the PCM companding codec: register map, field layout,
// format encodings and companding law figures.
// Assumes inclusion by bare name from the codec design file.
`ifndef PCMC_DEFINES_VH
`define PCMC_DEFINES_VH

// Register map (7-bit register address space)
`define PCMC_ADDR_W          7
`define PCMC_ADDR_FMT_CTRL   7'h01
`define PCMC_FMT_CTRL_RESET  8'h00

// Field positions inside pcm_format_control
`define PCMC_FLD_TRI         0
`define PCMC_FLD_GCI         1
`define PCMC_FLD_WIDTH       2
`define PCMC_FLD_FMT_LO      3
`define PCMC_FLD_FMT_HI      4
`define PCMC_FLD_ENABLE      5

// Encodings of companding_format_select
`define PCMC_FMT_ALAW        2'h0
`define PCMC_FMT_MULAW       2'h1
`define PCMC_FMT_LINEAR      2'h3

// Per-format inversion masks on the transmitted code
`define PCMC_MULAW_INV       8'h7F
`define PCMC_ALAW_INV        8'h55

// North-American law figures
`define PCMC_MU_BIAS         14'h0021
`define PCMC_MU_CLIP         14'h1FDE
`define PCMC_MU_SHIFT        2

// European law figures
`define PCMC_A_CLIP          13'h0FFF
`define PCMC_A_SHIFT         3

`endif

// file: logic/pcmc_codec.v
// PCM companding codec: linear samples to 8-bit companded codes and back.
// Assumes a single clk_sys domain; samples and codes come from logic on
// the same clock, and register writes arrive as one-cycle strobes.
//
// Function
// RQ1: Offer mu-law, A-law and linear sample formats
// RQ2: Code is sign, three segment, four step bits
// RQ3: Format field in mode register selects coding
// RQ4: Symmetric laws; sign bit one means positive
// RQ5: Mu-law inverts all seven magnitude bits
// RQ6: A-law inverts every even-numbered code bit
// RQ7: Mu-law segments 256 to 4, full scale 8159; code's segment 0 steps by 2
// RQ8: A-law segments 128 to 2, full scale 4096
// RQ9: Host never writes unmapped reserved addresses
// RQ10: Width bit enables 16-bit linear samples
// RQ11: Decoder outputs signed interval midpoint, same period
`timescale 1ns/100ps
`include "pcmc_defines.vh"

module pcmc_codec
(
  clk_sys,
  srst,
  reg_wr_en,
  reg_rd_en,
  reg_addr,
  reg_wr_data,
  reg_rd_data,
  tx_lin_valid,
  tx_lin_sample,
  tx_code_valid,
  tx_code,
  rx_code_valid,
  rx_code,
  rx_lin_valid,
  rx_lin_sample
);

  input  wire                      clk_sys;        // System clock, 10 MHz
  input  wire                      srst;           // Synchronous reset, active high
  input  wire                      reg_wr_en;      // Register write strobe
  input  wire                      reg_rd_en;      // Register read strobe
  input  wire [`PCMC_ADDR_W-1:0]   reg_addr;       // Register address
  input  wire [7:0]                reg_wr_data;    // Write data
  output reg  [7:0]                reg_rd_data;    // Read data, one cycle after strobe
  input  wire                      tx_lin_valid;   // Linear sample to encode
  input  wire [15:0]               tx_lin_sample;  // Two's complement sample
  output reg                       tx_code_valid;  // Encoded word ready
  output reg  [15:0]               tx_code;        // Code in low byte, or linear word
  input  wire                      rx_code_valid;  // Received word to decode
  input  wire [15:0]               rx_code;        // Code in low byte, or linear word
  output reg                       rx_lin_valid;   // Decoded sample ready
  output reg  [15:0]               rx_lin_sample;  // Two's complement sample

  //////////////////////////////////////////////////////////////////////////
  // Mode register
  //////////////////////////////////////////////////////////////////////////

  reg  [7:0] fmt_ctrl_reg;                           // pcm_format_control
  wire [1:0] companding_format_select;               // Active law
  wire       sample_width_select;                    // 1 selects 16-bit samples

  assign companding_format_select = fmt_ctrl_reg[`PCMC_FLD_FMT_HI:`PCMC_FLD_FMT_LO];
  assign sample_width_select      = fmt_ctrl_reg[`PCMC_FLD_WIDTH];

  // Writes to any other address are dropped; reserved space holds nothing
  always @(posedge clk_sys)
  begin
    if (srst)
      fmt_ctrl_reg <= `PCMC_FMT_CTRL_RESET;
    else if (reg_wr_en && reg_addr == `PCMC_ADDR_FMT_CTRL)  // [RQ3] [RQ9]
      fmt_ctrl_reg <= reg_wr_data;
  end

  // Reads of unmapped addresses return zero
  always @(posedge clk_sys)
  begin
    if (srst)
      reg_rd_data <= 8'h00;
    else if (reg_rd_en)
      reg_rd_data <= (reg_addr == `PCMC_ADDR_FMT_CTRL) ? fmt_ctrl_reg : 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Law functions
  //////////////////////////////////////////////////////////////////////////

  // Mu-law: bias by 33, segment is the top set bit of bits 12..5
  function [6:0] mu_encode;
    input [13:0] mag;
    reg   [13:0] biased;
    reg   [2:0]  seg;
    integer      i;
    begin
      biased = ((mag > `PCMC_MU_CLIP) ? `PCMC_MU_CLIP : mag) + `PCMC_MU_BIAS; // [RQ7]
      seg    = 3'h0;
      for (i = 0; i < 8; i = i + 1)
        if (biased[i + 5])
          seg = i[2:0];
      mu_encode = {seg, biased[seg + 4 -: 4]};     // [RQ2] [RQ7]
    end
  endfunction

  // Mu-law decode to the interval midpoint: ((2*step+33) << seg) - 33
  function [13:0] mu_decode;
    input [6:0] code;
    reg   [13:0] lvl;
    begin
      lvl       = {8'h00, code[3:0], 1'b0} + `PCMC_MU_BIAS;
      mu_decode = (lvl << code[6:4]) - `PCMC_MU_BIAS;  // [RQ11]
    end
  endfunction

  // A-law: first two segments share size 2, then doubling sizes upward
  function [6:0] a_encode;
    input [12:0] mag;
    reg   [12:0] m;
    reg   [2:0]  seg;
    integer      i;
    begin
      m   = (mag > `PCMC_A_CLIP) ? `PCMC_A_CLIP : mag;  // [RQ8]
      seg = 3'h0;
      for (i = 1; i < 8; i = i + 1)
        if (m[i + 4])
          seg = i[2:0];
      // Segment 0 and 1 both step by 2, so they use the same bit slice
      if (seg == 3'h0)
        a_encode = {seg, m[4:1]};                  // [RQ8]
      else
        a_encode = {seg, m[seg + 3 -: 4]};         // [RQ2] [RQ8]
    end
  endfunction

  // A-law decode to the interval midpoint
  function [12:0] a_decode;
    input [6:0] code;
    reg   [12:0] lvl;
    begin
      if (code[6:4] == 3'h0)
        a_decode = {8'h00, code[3:0], 1'b1};       // [RQ11]
      else
      begin
        lvl      = {7'h00, code[3:0], 1'b0} + 13'h0021;
        a_decode = lvl << (code[6:4] - 3'h1);      // [RQ11]
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Encoder
  //////////////////////////////////////////////////////////////////////////

  wire        tx_neg;                              // Sample below zero
  wire [16:0] tx_abs;                              // Magnitude, room for 32768
  wire [13:0] tx_mag_mu;                           // Scaled to mu-law range
  wire [12:0] tx_mag_a;                            // Scaled to A-law range

  assign tx_neg = tx_lin_sample[15];
  assign tx_abs = tx_neg ? (17'h10000 - {1'b0, tx_lin_sample}) : {1'b0, tx_lin_sample};
  // Largest magnitude 32768 shifts to 8192 or 4096; the mu-law clip handles 8192, and the A-law slice keeps 4096, which the A-law clip holds at 4095
  assign tx_mag_mu = (tx_abs >> `PCMC_MU_SHIFT) > 17'h01FFF ? 14'h1FFF
                   : tx_abs[`PCMC_MU_SHIFT +: 14];
  assign tx_mag_a  = tx_abs[`PCMC_A_SHIFT +: 13];

  // Registered so the code word leaves straight from a flip-flop
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      tx_code_valid <= 1'b0;
      tx_code       <= 16'h0000;
    end
    else
    begin
      tx_code_valid <= tx_lin_valid;
      if (tx_lin_valid)
      begin
        case (companding_format_select)            // [RQ1] [RQ3]
          `PCMC_FMT_MULAW:
            tx_code <= {8'h00, ({~tx_neg, mu_encode(tx_mag_mu)}             // [RQ4]
                                ^ `PCMC_MULAW_INV)};                        // [RQ5]
          `PCMC_FMT_ALAW:
            tx_code <= {8'h00, ({~tx_neg, a_encode(tx_mag_a)}               // [RQ4]
                                ^ `PCMC_ALAW_INV)};                         // [RQ6]
          `PCMC_FMT_LINEAR:
            // Narrow linear mode keeps only the top byte of the sample
            tx_code <= sample_width_select ? tx_lin_sample                  // [RQ10]
                                           : {8'h00, tx_lin_sample[15:8]};
          default:
            tx_code <= 16'h0000;                   // Reserved format sends silence
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decoder
  //////////////////////////////////////////////////////////////////////////

  wire [7:0]  rx_mu_plain;                         // Code with mu inversion removed
  wire [7:0]  rx_a_plain;                          // Code with A inversion removed
  wire [15:0] rx_mu_mag;                           // Mu magnitude at sample scale
  wire [15:0] rx_a_mag;                            // A magnitude at sample scale

  assign rx_mu_plain = rx_code[7:0] ^ `PCMC_MULAW_INV;            // [RQ5]
  assign rx_a_plain  = rx_code[7:0] ^ `PCMC_ALAW_INV;             // [RQ6]
  assign rx_mu_mag   = {mu_decode(rx_mu_plain[6:0]), 2'b00};
  assign rx_a_mag    = {a_decode(rx_a_plain[6:0]), 3'b000};

  // One cycle from code to level, well inside any sample period
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      rx_lin_valid  <= 1'b0;
      rx_lin_sample <= 16'h0000;
    end
    else
    begin
      rx_lin_valid <= rx_code_valid;                               // [RQ11]
      if (rx_code_valid)
      begin
        case (companding_format_select)            // [RQ1] [RQ3]
          `PCMC_FMT_MULAW:
            rx_lin_sample <= rx_mu_plain[7] ? rx_mu_mag            // [RQ4]
                                            : (16'h0000 - rx_mu_mag);
          `PCMC_FMT_ALAW:
            rx_lin_sample <= rx_a_plain[7] ? rx_a_mag              // [RQ4]
                                           : (16'h0000 - rx_a_mag);
          `PCMC_FMT_LINEAR:
            rx_lin_sample <= sample_width_select ? rx_code         // [RQ10]
                                                 : {rx_code[7:0], 8'h00};
          default:
            rx_lin_sample <= 16'h0000;
        endcase
      end
    end
  end

endmodule // pcmc_codec

// file: bench/pcmc_props.sv
// Checker for pcmc_codec: latency, code fields and register readback.
// Assumes a bind onto pcmc_codec; watches its ports only.
`timescale 1ns/100ps
module pcmc_props
(
  input logic        clk_sys,
  input logic        srst,
  input logic        reg_wr_en,
  input logic        reg_rd_en,
  input logic [6:0]  reg_addr,
  input logic [7:0]  reg_wr_data,
  input logic [7:0]  reg_rd_data,
  input logic        tx_lin_valid,
  input logic [15:0] tx_lin_sample,
  input logic        tx_code_valid,
  input logic [15:0] tx_code,
  input logic        rx_code_valid,
  input logic        rx_lin_valid
);
  logic [7:0] fmt_reg; // Shadow of the format register
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  // Shadow follows writes to the one mapped address
  always @(posedge clk_sys)
  begin
    if (srst)
      fmt_reg <= 8'h00;
    else if (reg_wr_en && reg_addr == 7'h01)
      fmt_reg <= reg_wr_data;
  end
  property p_tx; 1 |=> tx_code_valid == $past(tx_lin_valid); endproperty
  a_tx: assert property (p_tx) else $error("tx latency");
  property p_rx; 1 |=> rx_lin_valid == $past(rx_code_valid); endproperty
  a_rx: assert property (p_rx) else $error("rx latency");
  property p_hold; !tx_lin_valid |=> $stable(tx_code); endproperty
  a_hold: assert property (p_hold) else $error("tx code moved");
  property p_hi; tx_code_valid && $past(fmt_reg[4]) == 1'b0 |-> tx_code[15:8] == 8'h00;
  endproperty
  a_hi: assert property (p_hi) else $error("code not 8 bit");
  property p_sign; tx_code_valid && !$past(fmt_reg[4]) |-> tx_code[7] == !$past(tx_lin_sample[15]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign bit");
  property p_rd; reg_rd_en && reg_addr == 7'h01 |=> reg_rd_data == $past(fmt_reg); endproperty
  a_rd: assert property (p_rd) else $error("readback");
  property p_mu0;
    tx_code_valid && $past(fmt_reg[4:3]) == 2'h1 && $past(tx_lin_sample) == 16'h0000
      |-> tx_code == 16'h00FF;
  endproperty
  a_mu0: assert property (p_mu0) else $error("mu zero code");
  property p_a0;
    tx_code_valid && $past(fmt_reg[4:3]) == 2'h0 && $past(tx_lin_sample) == 16'h0000
      |-> tx_code == 16'h00D5;
  endproperty
  a_a0: assert property (p_a0) else $error("A zero code");
  c_mu: cover property (tx_code_valid && $past(fmt_reg[4:3]) == 2'h1);
  c_a: cover property (tx_code_valid && $past(fmt_reg[4:3]) == 2'h0);
  c_lin: cover property (rx_lin_valid && $past(fmt_reg[4:2], 2) == 3'h7);
endmodule // pcmc_props

// file: bench/pcmc_far.sv
// Far-end model: PCM highway looping encoder codes to the decoder.
// Assumes the codec clock; drives 1 ns after each rising edge.
`timescale 1ns/100ps
module pcmc_far
(
  input  logic        clk_sys,
  input  logic        tx_code_valid,
  input  logic [15:0] tx_code,
  output logic        rx_code_valid,
  output logic [15:0] rx_code
);
  initial
  begin
    rx_code_valid = 1'b0;
    rx_code = 16'h0000;
  end
  // Idle line toggles so a stale word never passes for a valid one
  always @(posedge clk_sys)
  begin
    #1;
    rx_code_valid = tx_code_valid;
    rx_code = tx_code_valid ? tx_code : ~rx_code;
  end
endmodule // pcmc_far

// file: bench/pcmc_tb.sv
// Testbench for pcmc_codec: every format and width, loopback decode.
// Assumes pcmc_far and pcmc_props compiled first.
`timescale 1ns/100ps
module tb;
  logic clk_sys, srst, reg_wr_en, reg_rd_en, tx_lin_valid, tx_code_valid;
  logic rx_code_valid, rx_lin_valid, w;
  logic [1:0] f;
  logic [6:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data, d;
  logic [15:0] tx_lin_sample, tx_code, rx_code, rx_lin_sample, eq_t[$], eq_r[$];
  logic [15:0] corner[6] = '{16'h0000, 16'h8000, 16'h7FFF, 16'hFFFF, 16'h7F7C, 16'h0084};
  logic [31:0] rnd;
  integer num_errors = 0, cmp_count = 0, cyc = 0, i, k;
  pcmc_codec u_dut (.clk_sys(clk_sys), .srst(srst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .tx_lin_valid(tx_lin_valid), .tx_lin_sample(tx_lin_sample),
    .tx_code_valid(tx_code_valid), .tx_code(tx_code), .rx_code_valid(rx_code_valid),
    .rx_code(rx_code), .rx_lin_valid(rx_lin_valid), .rx_lin_sample(rx_lin_sample));
  pcmc_far u_far (.clk_sys(clk_sys), .tx_code_valid(tx_code_valid), .tx_code(tx_code),
    .rx_code_valid(rx_code_valid), .rx_code(rx_code));
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  ////////////////////////////////////////////////////////////////
  // Expected code: clip, bias, find segment, take step, invert
  function logic [15:0] enc(input logic [1:0] f, input logic w, input logic [15:0] x);
    logic [15:0] a, m;
    integer n;
    begin
      a = x[15] ? 16'h0000 - x : x;
      n = 7;
      if (f == 2'h1)
      begin
        m = ((a >> 2) > 16'h1FDE ? 16'h1FDE : a >> 2) + 16'h0021;
        while (n > 0 && !m[n+5]) n--;
        enc = {8'h00, ~x[15], n[2:0], 4'(m >> (n + 1))} ^ 16'h007F;
      end
      else if (f == 2'h0)
      begin
        m = (a >> 3) > 16'h0FFF ? 16'h0FFF : a >> 3;
        while (n > 0 && !m[n+4]) n--;
        enc = {8'h00, ~x[15], n[2:0], 4'(m >> (n == 0 ? 1 : n))} ^ 16'h0055;
      end
      else
        enc = f == 2'h3 ? (w ? x : {8'h00, x[15:8]}) : 16'h0000;
    end
  endfunction
  // Expected decode: interval midpoint, scaled, sign applied
  function logic [15:0] dec(input logic [1:0] f, input logic w, input logic [15:0] r);
    logic [7:0] u;
    logic [15:0] m;
    begin
      u = r[7:0] ^ (f == 2'h1 ? 8'h7F : 8'h55);
      if (u[6:4] == 3'h0 && f == 2'h0)
        m = {u[3:0], 1'b1};
      else
        m = ({u[3:0], 1'b1} + 16'h0020) << (u[6:4] - (f == 2'h0));
      m = f == 2'h1 ? (m - 16'h0021) << 2 : m << 3;
      if (f[1])
        dec = f == 2'h3 ? (w ? r : {r[7:0], 8'h00}) : 16'h0000;
      else
        dec = u[7] ? m : 16'h0000 - m;
    end
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] v);
    @(posedge clk_sys); #1 reg_wr_en = 1; reg_addr = 7'h01; reg_wr_data = v;
    @(posedge clk_sys); #1 reg_wr_en = 0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_sys); #1 reg_rd_en = 1; reg_addr = a;
    @(posedge clk_sys); #1 reg_rd_en = 0;
    chk({8'h00, reg_rd_data}, {8'h00, e});
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Results are checked mid-cycle, where registered outputs have settled
  always @(negedge clk_sys)
  begin
    // An unknown or surplus valid is a mismatch, never a skipped check
    if (tx_code_valid !== 1'b0)
      chk(tx_code, (tx_code_valid === 1'b1 && eq_t.size() > 0) ?
          eq_t.pop_front() : ~tx_code);
    if (rx_lin_valid !== 1'b0)
      chk(rx_lin_sample, (rx_lin_valid === 1'b1 && eq_r.size() > 0) ?
          eq_r.pop_front() : ~rx_lin_sample);
  end
  // Hang guard, far above the roughly 190 cycles needed
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    srst = 1; reg_wr_en = 0; reg_rd_en = 0; reg_addr = 0; reg_wr_data = 0;
    tx_lin_valid = 0; tx_lin_sample = 0; rnd = 32'hC66E0ABC;
    repeat (4) @(posedge clk_sys);
    #1 srst = 0;
    rd(7'h01, 8'h00);
    rd(7'h02, 8'h00);
    for (k = 0; k < 8; k++)
    begin
      f = k[2:1];
      w = k[0];
      rnd = lfsr(rnd);
      d = {rnd[7:5], f, w, rnd[1:0]};
      wr(d);
      rd(7'h01, d);
      for (i = 0; i < 14; i++)
      begin
        rnd = lfsr(rnd);
        @(posedge clk_sys); #1 tx_lin_valid = 1;
        tx_lin_sample = i < 6 ? corner[i] : rnd[15:0];
        eq_t.push_back(enc(f, w, tx_lin_sample));
        eq_r.push_back(dec(f, w, enc(f, w, tx_lin_sample)));
      end
      @(posedge clk_sys); #1 tx_lin_valid = 0;
      repeat (3) @(posedge clk_sys);
      $display("format %0d width %0d done", f, w);
    end
    // Every queued expectation must have met its valid pulse
    chk(16'(eq_t.size()), 16'h0000);
    chk(16'(eq_r.size()), 16'h0000);
    // Reset in mid-run must bring the format register back to its reset value
    @(posedge clk_sys);
    #1 srst = 1;
    repeat (2) @(posedge clk_sys);
    #1 srst = 0;
    rd(7'h01, 8'h00);
    $display("mid-run reset done");
    conclude();
  end
endmodule // tb
bind pcmc_codec pcmc_props u_props (.clk_sys(clk_sys), .srst(srst), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data), .tx_lin_valid(tx_lin_valid), .tx_lin_sample(tx_lin_sample),
  .tx_code_valid(tx_code_valid), .tx_code(tx_code), .rx_code_valid(rx_code_valid),
  .rx_lin_valid(rx_lin_valid));
